/* File: rtl/owf_window_fringe_ctrl.sv */
// owf_window_fringe_ctrl: osd vertical window, per-row fringing and port-6 pin routing
// assumes classic wishbone master, hsync/vsync one-cycle pulses synchronous to clk_i
`timescale 1ns/10ps
module owf_window_fringe_ctrl #(
  parameter int ADR_W = 14,
  parameter int LINE_W = 10,
  parameter int HW = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic [3:0] osd_rgbyl_i,
  input wire logic [3:0] port6_latch_i,
  input wire logic [2:0] row_sel_i,
  input wire logic [HW-1:0] base_height_i,
  output logic [3:0] osd_rgbyl_o,
  output logic [3:0] port6_pin_o,
  output logic [HW:0] row_height_o,
  output logic in_window_o
);
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [7:0] osd_main_control_reg, ctrl_next;
  logic [7:0] line_fringe_enable_reg, fringe_next;
  logic [3:0] port6_output_route_reg, route_next;
  logic [7:0] window_upper_limit_reg, upper_next;
  logic [7:0] window_lower_limit_reg, lower_next;
  logic [LINE_W-1:0] line_cnt_reg, line_cnt_next;
  logic in_win_reg, in_win_next;
  logic [3:0] osd_reg, osd_next;
  logic [3:0] pin_reg, pin_next;
  logic [LINE_W-1:0] window_top_position;
  logic [LINE_W-1:0] window_bottom_position;
  logic window_function_on, vertical_display_mode_sel, show;
  logic wr_commit;

  // index match on a word address, used by the write and read decoders
  function automatic logic idx_hit(input logic [ADR_W-1:0] adr, input logic [11:0] idx);
    idx_hit = (adr[ADR_W-1:2] == idx[ADR_W-3:0]);
  endfunction

  // write lands at the edge where the master samples ack high
  assign wr_commit = cyc_i & stb_i & we_i & ack_reg & sel_i[0];
  assign window_function_on = osd_main_control_reg[owf_pkg::CTRL_WIN_BIT];
  assign vertical_display_mode_sel = osd_main_control_reg[owf_pkg::CTRL_VMODE_BIT];

  // bus slave: ack one cycle after request, dropped the cycle after
  always_comb begin
    ack_next = cyc_i & stb_i & ~ack_reg;
    dat_next = 32'h0000_0000;
    // registers are write-only; only status reads back, unmapped reads zero
    if (idx_hit(adr_i, owf_pkg::IDX_STATUS)) begin
      dat_next[LINE_W-1:0] = line_cnt_reg;
      dat_next[owf_pkg::STAT_INWIN_BIT] = in_win_reg;
    end
    ctrl_next = osd_main_control_reg;
    fringe_next = line_fringe_enable_reg;
    route_next = port6_output_route_reg;
    upper_next = window_upper_limit_reg;
    lower_next = window_lower_limit_reg;
    // whole-byte stores only; no partial field update is offered
    if (wr_commit) begin
      if (idx_hit(adr_i, owf_pkg::IDX_CTRL)) begin
        ctrl_next = dat_i[7:0];
      end
      if (idx_hit(adr_i, owf_pkg::IDX_FRINGE)) begin
        fringe_next = dat_i[7:0];
      end
      if (idx_hit(adr_i, owf_pkg::IDX_ROUTE)) begin
        route_next = dat_i[7:owf_pkg::ROUTE_LSB];
      end
      if (idx_hit(adr_i, owf_pkg::IDX_UPPER)) begin
        upper_next = dat_i[7:0];
      end
      if (idx_hit(adr_i, owf_pkg::IDX_LOWER)) begin
        lower_next = dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      osd_main_control_reg <= owf_pkg::CTRL_RST;
      line_fringe_enable_reg <= owf_pkg::FRINGE_RST;
      port6_output_route_reg <= owf_pkg::ROUTE_RST;
      window_upper_limit_reg <= owf_pkg::UPPER_RST;
      window_lower_limit_reg <= owf_pkg::LOWER_RST;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      osd_main_control_reg <= ctrl_next;
      line_fringe_enable_reg <= fringe_next;
      port6_output_route_reg <= route_next;
      window_upper_limit_reg <= upper_next;
      window_lower_limit_reg <= lower_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // window positions in line periods; normal mode counts in pairs of lines
  always_comb begin
    if (vertical_display_mode_sel) begin
      window_top_position = LINE_W'(window_upper_limit_reg);
      window_bottom_position = LINE_W'(window_lower_limit_reg);
    end else begin
      window_top_position = LINE_W'({window_upper_limit_reg, 1'b0});
      window_bottom_position = LINE_W'({window_lower_limit_reg, 1'b0});
    end
  end

  // line counter restarts on vsync; saturates so a missing vsync cannot wrap into view
  always_comb begin
    line_cnt_next = line_cnt_reg;
    if (vsync_i) begin
      line_cnt_next = '0;
    end else if (hsync_i && line_cnt_reg != {LINE_W{1'b1}}) begin
      line_cnt_next = line_cnt_reg + 1'b1;
    end
    in_win_next = (line_cnt_reg >= window_top_position) &&
                  (line_cnt_reg < window_bottom_position);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_cnt_reg <= '0;
      in_win_reg <= 1'b0;
    end else begin
      line_cnt_reg <= line_cnt_next;
      in_win_reg <= in_win_next;
    end
  end

  assign in_window_o = in_win_reg;

  // gate osd colour outside the window; timing inputs keep running regardless
  assign show = osd_main_control_reg[owf_pkg::CTRL_DISP_BIT] &
                (~window_function_on | in_win_reg);

  always_comb begin
    osd_next = osd_rgbyl_i & {4{show}};
  end

  // per-pin choice between port latch and osd signal
  for (genvar g = 0; g < 4; g++) begin : g_route
    always_comb begin
      pin_next[g] = port6_output_route_reg[g] ? osd_next[g] : port6_latch_i[g];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osd_reg <= 4'h0;
      pin_reg <= 4'h0;
    end else begin
      osd_reg <= osd_next;
      pin_reg <= pin_next;
    end
  end

  assign osd_rgbyl_o = osd_reg;
  assign port6_pin_o = pin_reg;

  owf_row_sizer #(
    .HW(HW)
  ) u_sizer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_fringe_on_i(line_fringe_enable_reg),
    .row_sel_i(row_sel_i),
    .base_height_i(base_height_i),
    .row_height_o(row_height_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_win_off;
    !window_function_on && osd_main_control_reg[0] |=> osd_rgbyl_o == $past(osd_rgbyl_i);
  endproperty
  a_win_off: assert property (p_win_off) else $error("disabled window still gates osd");

  property p_upper_wr;
    wr_commit && idx_hit(adr_i, owf_pkg::IDX_UPPER) |=> window_upper_limit_reg == $past(dat_i[7:0]);
  endproperty
  a_upper_wr: assert property (p_upper_wr) else $error("upper limit not stored");

  property p_lower_wr;
    wr_commit && idx_hit(adr_i, owf_pkg::IDX_LOWER) |=> window_lower_limit_reg == $past(dat_i[7:0]);
  endproperty
  a_lower_wr: assert property (p_lower_wr) else $error("lower limit not stored");

  property p_top_edge;
    !vertical_display_mode_sel && window_lower_limit_reg > window_upper_limit_reg &&
      line_cnt_reg == LINE_W'({window_upper_limit_reg, 1'b0}) |=> in_win_reg;
  endproperty
  a_top_edge: assert property (p_top_edge) else $error("window not open at top line");

  property p_bottom_edge;
    !vertical_display_mode_sel && line_cnt_reg == LINE_W'({window_lower_limit_reg, 1'b0})
      |=> !in_win_reg;
  endproperty
  a_bottom_edge: assert property (p_bottom_edge) else $error("window open at bottom line");

  property p_outside_dark;
    window_function_on && !in_win_reg |=> osd_rgbyl_o == 4'h0;
  endproperty
  a_outside_dark: assert property (p_outside_dark) else $error("osd shown outside window");

  property p_inside_pass;
    window_function_on && in_win_reg && osd_main_control_reg[0]
      |=> osd_rgbyl_o == $past(osd_rgbyl_i);
  endproperty
  a_inside_pass: assert property (p_inside_pass) else $error("osd lost inside window");

  property p_route_latch;
    !port6_output_route_reg[0] |=> port6_pin_o[0] == $past(port6_latch_i[0]);
  endproperty
  a_route_latch: assert property (p_route_latch) else $error("pin not fed by latch");

  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  c_upper_wr: cover property (wr_commit && idx_hit(adr_i, owf_pkg::IDX_UPPER));
  c_win_open: cover property (window_function_on && $rose(in_win_reg));
  c_route_osd: cover property (port6_output_route_reg[3] && osd_rgbyl_o[3]);
endmodule

/* File: rtl/owf_pkg.sv */
// owf_pkg: register map, field positions and reset values of the osd window/fringe slice
// assumes a 32-bit classic wishbone bus, one register per aligned word
package owf_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL = 12'hF8F;
  localparam logic [11:0] IDX_FRINGE = 12'hF90;
  localparam logic [11:0] IDX_ROUTE = 12'hF91;
  localparam logic [11:0] IDX_UPPER = 12'hF92;
  localparam logic [11:0] IDX_LOWER = 12'hF93;
  localparam logic [11:0] IDX_STATUS = 12'hF9F;
  // control register fields
  localparam int CTRL_DISP_BIT = 0;
  localparam int CTRL_WIN_BIT = 1;
  localparam int CTRL_VMODE_BIT = 3;
  // route register uses bits 7..4 only
  localparam int ROUTE_LSB = 4;
  // status register fields
  localparam int STAT_INWIN_BIT = 10;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FRINGE_RST = 8'h00;
  localparam logic [3:0] ROUTE_RST = 4'h0;
  localparam logic [7:0] UPPER_RST = 8'h00;
  localparam logic [7:0] LOWER_RST = 8'h00;
  // number of character rows with their own fringe bit
  localparam int ROWS = 8;
endpackage

/* File: rtl/owf_row_sizer.sv */
// owf_row_sizer: vertical dot height of the character row being drawn
// assumes row index and base height come synchronously from the renderer
`timescale 1ns/10ps
module owf_row_sizer #(
  parameter int HW = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] line_fringe_on_i,
  input wire logic [2:0] row_sel_i,
  input wire logic [HW-1:0] base_height_i,
  output logic [HW:0] row_height_o
);
  logic [HW:0] row_height_reg;
  logic [HW:0] row_height_next;

  // one extra dot whatever the font; adjacent rows with no gap may then overlap
  always_comb begin
    row_height_next = {1'b0, base_height_i} + {{HW{1'b0}}, line_fringe_on_i[row_sel_i]};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row_height_reg <= '0;
    end else begin
      row_height_reg <= row_height_next;
    end
  end

  assign row_height_o = row_height_reg;

  property p_fringe_grow;
    @(posedge clk_i) disable iff (rst_i)
      line_fringe_on_i[row_sel_i] |=> row_height_o == {1'b0, $past(base_height_i)} + 1'b1;
  endproperty
  a_fringe_grow: assert property (p_fringe_grow) else $error("fringed row not one dot taller");

  property p_fringe_off;
    @(posedge clk_i) disable iff (rst_i)
      !line_fringe_on_i[row_sel_i] |=> row_height_o == {1'b0, $past(base_height_i)};
  endproperty
  a_fringe_off: assert property (p_fringe_off) else $error("plain row height changed");

  c_fringe_row: cover property (@(posedge clk_i) disable iff (rst_i) line_fringe_on_i[7]);
endmodule

/* File: verif/test_owf_window_fringe_ctrl.sv */
// test_owf_window_fringe_ctrl: self-checking bench for the osd window/fringe slice
// assumes the design's own assertions; drives wishbone and video pins itself
`timescale 1ns/10ps
module test_owf_window_fringe_ctrl;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, hsync_i, vsync_i, ack_o, in_window_o;
  logic [13:0] adr_i;
  logic [3:0] sel_i, osd_rgbyl_i, port6_latch_i, osd_rgbyl_o, port6_pin_o;
  logic [31:0] dat_i, dat_o, seed, q;
  logic [2:0] row_sel_i;
  logic [4:0] base_height_i;
  logic [5:0] row_height_o;
  logic [7:0] f, u, l, rt;
  logic [3:0] eo, ep;
  logic ew;
  int err_count, tests_run;

  owf_window_fringe_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .hsync_i(hsync_i), .vsync_i(vsync_i), .osd_rgbyl_i(osd_rgbyl_i),
    .port6_latch_i(port6_latch_i), .row_sel_i(row_sel_i), .base_height_i(base_height_i),
    .osd_rgbyl_o(osd_rgbyl_o), .port6_pin_o(port6_pin_o), .row_height_o(row_height_o),
    .in_window_o(in_window_o));

  // 25 mhz clock
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end

  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // mode 1 counts single lines, normal mode pairs of lines
  function automatic logic exp_in(int line, logic [7:0] up, logic [7:0] lo, logic m);
    int k;
    k = m ? 1 : 2;
    return (line >= k * up) && (line < k * lo);
  endfunction

  // a fringed row is one dot taller than its font, a plain row keeps it
  function automatic logic [31:0] exp_h(input logic [4:0] b, input logic fr);
    return {26'h0, {1'b0, b} + {5'h00, fr}};
  endfunction

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one classic cycle, whole-byte store only, no read-modify-write
  task wb(input logic [11:0] idx, input logic w, input logic [3:0] s, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    sel_i <= s;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    if (n >= 20) begin
      err_count++;
      $display("[FAIL] ack expected 1 seen none");
      results;
    end
  endtask

  // one sync pulse, then let counter, window flag and gating settle
  task vpulse(input logic v);
    @(posedge clk_i);
    hsync_i <= !v;
    vsync_i <= v;
    @(posedge clk_i);
    hsync_i <= 0;
    vsync_i <= 0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  initial begin
    {cyc_i, stb_i, we_i, hsync_i, vsync_i, adr_i, sel_i, dat_i} = '0;
    {port6_latch_i, row_sel_i, base_height_i} = '0;
    osd_rgbyl_i = 4'hF;
    rst_i = 1;
    seed = 32'h00006DCD;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    // write-only places, the status register after reset and an unmapped place all read back zero
    for (int i = 0; i < 7; i++) begin
      wb(i == 6 ? 12'h000 : 12'hF8F + i[11:0] + (i == 5 ? 12'h00B : 12'h000), 0, 4'hF, 8'h00);
      chk("read zero", 32'h0, q);
    end
    chk("osd after reset", 32'h0, {28'h0, osd_rgbyl_o});
    $display("reset test done");
    // fringe: corner patterns then random ones, each row in turn
    for (int t = 0; t < 6; t++) begin
      f = t == 0 ? 8'h00 : t == 1 ? 8'hFF : t == 2 ? 8'h01 : 8'(rnd());
      wb(owf_pkg::IDX_FRINGE, 1, 4'hF, f);
      wb(owf_pkg::IDX_FRINGE, 1, 4'hE, ~f);
      for (int r = 0; r < 8; r++) begin
        @(posedge clk_i);
        row_sel_i <= r[2:0];
        base_height_i <= 5'(rnd());
        repeat (2) @(posedge clk_i);
        #1;
        chk("row height", exp_h(base_height_i, f[r]), {26'h0, row_height_o});
      end
    end
    $display("fringe test done");
    // window on and off in both vertical modes
    for (int c = 0; c < 4; c++) begin
      u = 8'h01 + 8'(rnd() % 4);
      l = u + 8'h01 + 8'(rnd() % 3);
      rt = 8'(rnd());
      wb(owf_pkg::IDX_UPPER, 1, 4'hF, u);
      wb(owf_pkg::IDX_LOWER, 1, 4'hF, l);
      wb(owf_pkg::IDX_ROUTE, 1, 4'hF, rt);
      wb(owf_pkg::IDX_CTRL, 1, 4'hF, {4'h0, c[1], 1'b0, c[0], 1'b1});
      @(posedge clk_i);
      osd_rgbyl_i <= 4'(rnd());
      port6_latch_i <= 4'(rnd());
      vpulse(1);
      for (int n = 0; n <= 2 * l + 1; n++) begin
        if (n > 0) vpulse(0);
        ew = c[0] ? exp_in(n, u, l, c[1]) : 1'b1;
        if (c[0]) chk("in window", {31'h0, ew}, {31'h0, in_window_o});
        eo = ew ? osd_rgbyl_i : 4'h0;
        chk("osd out", {28'h0, eo}, {28'h0, osd_rgbyl_o});
        ep = (rt[7:4] & eo) | (~rt[7:4] & port6_latch_i);
        chk("pins", {28'h0, ep}, {28'h0, port6_pin_o});
      end
      wb(owf_pkg::IDX_STATUS, 0, 4'hF, 8'h00);
      chk("line count", 2 * l + 1, {22'h0, q[9:0]});
    end
    $display("window test done");
    results;
  end
endmodule
